// >>> src/sacs_seq.sv
// Purpose: Digital sequencer of a 10-bit serial SAR converter
// Assumes: clk 10 MHz; serial clock and trigger are asynchronous pins
// Notes:   Sample word arrives from the converter core on clk
`timescale 1ns/100ps
`include "sacs_map.svh"

////////////////////////////////////////////////////////////////////////////
module sacs_fifo #(
  parameter int W = `SACS_SAMPLE_W,
  parameter int D = `SACS_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // Drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;

  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_d  = push ? AW'(wr_q + 1'b1) : wr_q;
    rd_d  = pop ? AW'(rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = (AW+1)'(cnt_q + 1'b1);
    end else if (pop && !push) begin
      cnt_d = (AW+1)'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule // sacs_fifo

////////////////////////////////////////////////////////////////////////////
module sacs_seq
  import sacs_pkg::*;
(
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst_n,
  // Serial link pins
  input  wire logic   serial_clk,
  input  wire logic   conversion_trigger,
  output logic        dout,
  output logic        dout_oe,
  // Converter core side
  input  sacs_sample_t sample_in,
  output logic        sample_ready,
  // Status
  output logic        track,
  output logic        partial_pd,
  output logic        restart,
  output logic        conv_done,
  output logic        result_ok
);
  // Synchronisers and edge finders
  logic [2:0] sck_q, trg_q;
  logic       sclk_rise, trig_fall, trig_rise;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_q <= 3'h0;
      trg_q <= 3'h7;
    end else begin
      sck_q <= {sck_q[1:0], serial_clk};
      trg_q <= {trg_q[1:0], conversion_trigger};
    end
  end

  assign sclk_rise = sck_q[1] && !sck_q[2];
  assign trig_fall = !trg_q[1] && trg_q[2];
  assign trig_rise = trg_q[1] && !trg_q[2];

  //////////////////////////////////////////////////////////////////////////
  // Sample buffer
  logic         pop_req, fifo_valid;
  logic [11:0]  fifo_data;

  sacs_fifo #(.W(`SACS_SAMPLE_W), .D(`SACS_FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (trig_fall),
    .in_ready  (sample_ready),
    .in_data   (sample_in),
    .out_valid (fifo_valid),
    .out_ready (pop_req),
    .out_data  (fifo_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // Sequencer state
  sacs_state_t state_q, state_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [11:0] frame_q, frame_d;
  logic        restart_q, restart_d;
  logic        dout_q, dout_d, oe_q, oe_d, track_q, track_d;
  logic        done_q, done_d, ok_q, ok_d, hold;

  assign hold    = (state_q == ST_HOLD);
  assign pop_req = hold && sclk_rise && (cnt_q == `SACS_POP_EDGE);

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    restart_d = restart_q;
    frame_d   = frame_q;
    dout_d    = dout_q;
    oe_d      = oe_q;
    done_d    = 1'b0;
    if (trig_fall) begin
      cnt_d = `SACS_CNT_RST;
    end else if (sclk_rise && cnt_q != `SACS_CNT_MAX) begin
      cnt_d = cnt_q + 5'd1;
    end
    case (state_q)
      ST_TRACK: begin
        if (trig_fall) begin
          state_d = ST_HOLD;
        end
      end
      ST_PPD: begin
        if (trig_fall) begin
          state_d   = ST_HOLD;
          restart_d = 1'b1;
        end
      end
      ST_HOLD: begin
        if (trig_rise) begin
          if (cnt_q >= `SACS_PPD_FIRST && cnt_q < `SACS_TRACK_EDGE) begin
            state_d = ST_PPD;
          end else begin
            state_d = ST_TRACK;
          end
        end
      end
      default: begin
        state_d = ST_TRACK;
      end
    endcase
    done_d = sclk_rise && !trig_fall && (state_q != ST_PPD) &&
             (cnt_q == `SACS_LAST_BIT_EDGE);
    if (done_d) begin
      restart_d = 1'b0;
    end
    ok_d = done_d && !restart_q;
    if (pop_req) begin
      frame_d = fifo_valid ? fifo_data : 12'h000;
    end
    if (trig_fall) begin
      dout_d = 1'b0;
      oe_d   = 1'b1;
    end else if (trig_rise) begin
      oe_d = 1'b0;
    end else if (hold && sclk_rise) begin
      if (cnt_d >= `SACS_MSB_EDGE && cnt_d <= `SACS_LAST_BIT_EDGE) begin
        dout_d = frame_q[4'(`SACS_LAST_BIT_EDGE - cnt_d)];
      end else begin
        dout_d = 1'b0;
      end
      if (cnt_q == `SACS_CONV_EDGES) begin
        oe_d = 1'b0;
      end
    end
    track_d = (state_d != ST_HOLD) || (cnt_d >= `SACS_TRACK_EDGE);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q   <= ST_TRACK;
      cnt_q     <= `SACS_CNT_RST;
      restart_q <= `SACS_RESTART_RST;
      frame_q   <= 12'h000;
      dout_q    <= 1'b0;
      oe_q      <= 1'b0;
      track_q   <= 1'b1;
      done_q    <= 1'b0;
      ok_q      <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      restart_q <= restart_d;
      frame_q   <= frame_d;
      dout_q    <= dout_d;
      oe_q      <= oe_d;
      track_q   <= track_d;
      done_q    <= done_d;
      ok_q      <= ok_d;
    end
  end

  assign dout       = dout_q;
  assign dout_oe    = oe_q;
  assign track      = track_q;
  assign partial_pd = (state_q == ST_PPD);
  assign restart    = restart_q;
  assign conv_done  = done_q;
  assign result_ok  = ok_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_cnt_clear: assert property (trig_fall |=> cnt_q == 5'd0)
    else $error("edge counter not cleared at trigger fall");
  chk_conv_len: assert property (
    hold && sclk_rise && !trig_fall && !trig_rise && cnt_q == 5'd15
    |=> conv_done && cnt_q == 5'd16)
    else $error("conversion end not at sixteenth edge");
  chk_track_start: assert property (
    hold && !trig_fall && !trig_rise && sclk_rise && cnt_q == 5'd13
    |=> track && hold)
    else $error("tracking did not start at fourteenth edge");
  chk_idle_track: assert property (state_q == ST_TRACK |-> track)
    else $error("idle without tracking");
  chk_start_fall: assert property (
    trig_fall |=> state_q == ST_HOLD && !track)
    else $error("trigger fall did not start a hold");
  chk_step_clock: assert property (
    $changed(cnt_q) |-> $past(sclk_rise || trig_fall))
    else $error("counter moved without serial clock");
  chk_dout_edge: assert property (
    $changed(dout) |-> $past(sclk_rise || trig_fall))
    else $error("data changed off a rising edge");
  chk_msb_edge: assert property (
    hold && $changed(cnt_q) && cnt_q == 5'd4 |-> dout == frame_q[11])
    else $error("MSB not on fourth edge");
  chk_lead_zero: assert property (
    hold && cnt_q < 5'd4 && $past(hold) |-> !dout)
    else $error("leading bits not zero");
  chk_ppd_entry: assert property (
    hold && trig_rise && !trig_fall && cnt_q >= 5'd3 && cnt_q < 5'd14
    |=> partial_pd ##1 (partial_pd || state_q == ST_HOLD))
    else $error("partial power-down not entered");
  chk_restart: assert property (
    partial_pd && trig_fall |=> restart && !result_ok)
    else $error("restart conversion not flagged");
endmodule // sacs_seq

// >>> src/sacs_map.svh
// Purpose: Offsets, counts and reset values for the conversion sequencer
// Assumes: Counts are in serial clock rising edges unless noted
// Notes:   Definitions only
`ifndef SACS_MAP_SVH
`define SACS_MAP_SVH

// Edge counts within one conversion
`define SACS_POP_EDGE      5'd2
`define SACS_PPD_FIRST     5'd3
`define SACS_MSB_EDGE      5'd4
`define SACS_TRACK_EDGE    5'd14
`define SACS_LAST_BIT_EDGE 5'd15
`define SACS_CONV_EDGES    5'd16
`define SACS_CNT_MAX       5'd17

// Result framing and buffering
`define SACS_CODE_W        10
`define SACS_SAMPLE_W      12
`define SACS_FIFO_DEPTH    16

// Reset values
`define SACS_CNT_RST       5'd0
`define SACS_RESTART_RST   1'b0

`endif

// >>> src/sacs_pkg.sv
// Purpose: Types shared by the conversion sequencer
// Assumes: Constants come from sacs_map.svh
// Notes:   Types only
`include "sacs_map.svh"

package sacs_pkg;

  typedef struct packed {
    logic [`SACS_CODE_W-1:0] code;
    logic                    sub_bit_upper;
    logic                    sub_bit_lower;
  } sacs_sample_t;

  typedef enum logic [1:0] {
    ST_TRACK = 2'b00,
    ST_HOLD  = 2'b01,
    ST_PPD   = 2'b10
  } sacs_state_t;

endpackage

// >>> dv/sacs_host.sv
// Purpose: Host serial port model for the converter link
// Assumes: Serial clock period 800 ns, low between frames
// Notes:   Bench calls the tasks; steps land on clk falling edges
`timescale 1ns/100ps

module sacs_host (
  // Clock
  input  wire logic clk,
  // Link pins
  output logic      serial_clk,
  output logic      conversion_trigger,
  input  wire logic dout,
  input  wire logic dout_oe
);
  initial begin
    serial_clk         = 1'b0;
    conversion_trigger = 1'b1;
  end

  ////////////////////////////////////////
  // Arm high, then fall to start
  task automatic start();
    @(negedge clk);
    conversion_trigger = 1'b1;
    #800;
    conversion_trigger = 1'b0;
    #800;
  endtask

  // One serial clock, data read just before next rise
  task automatic pulse(output logic d, output logic oe);
    serial_clk = 1'b1;
    #400;
    serial_clk = 1'b0;
    #400;
    d  = dout_oe ? dout : ~dout;
    oe = dout_oe;
  endtask

  // Wait out the power-up time after full power-down
  task automatic power_up();
    #2000000;
  endtask

  // Release trigger
  task automatic finish();
    conversion_trigger = 1'b1;
  endtask
endmodule // sacs_host

// >>> dv/sacs_seq_test.sv
// Purpose: Self-checking bench of the conversion sequencer
// Assumes: clk 100 ns, host serial clock 800 ns
// Notes:   Full power-down wait is host side only
`timescale 1ns/100ps

module sacs_seq_test;
  import sacs_pkg::*;
  logic         clk, rst_n, serial_clk, conversion_trigger, dout, dout_oe;
  logic         sample_ready, track, partial_pd, restart, conv_done;
  logic         result_ok, d, oe;
  sacs_sample_t sample_in;
  int           failures = 0, n_compared = 0, n_done = 0, n_ok = 0;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  sacs_seq dut_u (.clk(clk), .rst_n(rst_n), .serial_clk(serial_clk),
    .conversion_trigger(conversion_trigger), .dout(dout),
    .dout_oe(dout_oe), .sample_in(sample_in), .sample_ready(sample_ready),
    .track(track), .partial_pd(partial_pd), .restart(restart),
    .conv_done(conv_done), .result_ok(result_ok));
  sacs_host host_u (.clk(clk), .serial_clk(serial_clk),
    .conversion_trigger(conversion_trigger), .dout(dout),
    .dout_oe(dout_oe));

  always @(posedge clk) begin
    n_done <= n_done + int'(conv_done === 1'b1);
    n_ok   <= n_ok + int'(result_ok === 1'b1);
  end

  ////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One conversion, trigger released after edge rise_at
  task automatic conv(input int rise_at, input int n, input sacs_sample_t s,
                      output logic [15:0] bits);
    int nd;
    nd = n_done;
    bits = '0;
    sample_in = s;
    host_u.start();
    sample_in = sacs_sample_t'(~s);
    check(dout_oe, 1'b1);
    check(track, 1'b0);
    repeat (10) @(negedge clk);
    check(16'(n_done - nd), 16'h0);
    for (int k = 1; k <= n; k++) begin
      host_u.pulse(d, oe);
      bits[16-k] = d;
      check(oe, k <= rise_at);
      if (k == 3 || k == 14) check(track, k == 14);
      if (k == rise_at) host_u.finish();
    end
  endtask

  task automatic t_frames();
    logic [15:0] got;
    int          no;
    no = n_ok;
    conv(15, 16, '{10'h2a5, 1'b1, 1'b0}, got);
    check(got[15:1], {3'b000, 10'h2a5, 2'b10});
    conv(15, 16, '{10'h15a, 1'b0, 1'b1}, got);
    check(got[15:1], {3'b000, 10'h15a, 2'b01});
    check(16'(n_ok - no), 16'h2);
    check(track, 1'b1);
    $display("t_frames done");
  endtask

  task automatic t_partial();
    logic [15:0] got;
    int          nd, no;
    conv(5, 5, '{10'h3ff, 1'b1, 1'b1}, got);
    repeat (4) @(negedge clk);
    check({partial_pd, dout_oe}, 2'b10);
    nd = n_done;
    no = n_ok;
    conv(15, 16, '{10'h001, 1'b0, 1'b0}, got);
    check(16'(n_done - nd), 16'h1);
    check(16'(n_ok - no), 16'h0);
    check({partial_pd, restart}, 2'b00);
    conv(15, 16, '{10'h200, 1'b0, 1'b1}, got);
    check(got[15:1], {3'b000, 10'h200, 2'b01});
    check(16'(n_ok - no), 16'h1);
    $display("t_partial done");
  endtask

  task automatic t_fill();
    for (int i = 1; i <= 16; i++) begin
      sample_in = sacs_sample_t'(12'(i));
      host_u.start();
      host_u.finish();
      repeat (4) @(negedge clk);
      check(sample_ready, i < 16);
    end
    $display("t_fill done");
  endtask

  task automatic print_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    sample_in = '0;
    repeat (6) @(negedge clk);
    check({dout_oe, track, partial_pd, restart, conv_done, sample_ready},
          6'b010001);
    rst_n = 1'b1;
    host_u.power_up();
    t_frames();
    t_partial();
    t_fill();
    print_verdict();
  end

  initial begin
    #2500000;
    failures++;
    $display("unexpected at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule // sacs_seq_test
